/* File: src/sdgp_pin_share.sv */
// Pin sharing of eight module pins between general purpose I/O and an SD card link.
// Assumes the SD host logic on ref_clk supplies one bit slot per SD clock via a
// valid/ready handshake; the SD clock is derived from ref_clk by a divider.
// Pin inputs are asynchronous and pass two flip-flops; gp_in_clk is the carrier
// logic clock for the general purpose inputs, a second domain.
`timescale 1ns/1ps
`include "sdgp_defs.svh"
module sdgp_pin_share
  import sdgp_pkg::*;
(
  // System clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Carrier side clock for sampled general purpose inputs
  input wire logic gp_in_clk,
  // Control from the module
  input wire logic sd_mode,
  input wire logic cmd_init,
  input wire logic [3:0] gen_out_val,
  input wire logic [`SDGP_DIV_W-1:0] clk_half,
  // Bit slot stream from the SD host logic
  input wire logic slot_valid,
  input wire sdgp_bits_s slot_tx,
  input wire sdgp_drive_s slot_drv,
  output logic slot_ready,
  output sdgp_bits_s slot_rx,
  output logic slot_rx_valid,
  // Status back to the module
  output logic [3:0] gen_in_level,
  output logic card_present,
  output logic card_wp,
  // Clock pin shared with gen_out_zero
  output logic gen_out_zero,
  // Command pin shared with gen_out_one
  input wire logic gen_out_one_in,
  output logic gen_out_one,
  output logic gen_out_one_oe,
  // Write protect pin shared with gen_out_two
  input wire logic gen_out_two_in,
  output logic gen_out_two,
  output logic gen_out_two_oe,
  // Card detect pin shared with gen_out_three
  input wire logic card_present_n,
  output logic gen_out_three,
  output logic gen_out_three_oe,
  // Data pins shared with gen_in_zero..three
  input wire logic [3:0] card_data_in,
  output logic [3:0] card_data_out,
  output logic [3:0] card_data_oe
);

  sdgp_mode_e mode; // Registered mode, one for all pins
  sdgp_state_e state; // Shift engine state
  logic [`SDGP_DIV_W-1:0] div_cnt; // Half period counter
  logic [`SDGP_DIV_W-1:0] half_eff; // Clamped half period
  sdgp_bits_s cur_tx; // Slot on the wire
  sdgp_drive_s cur_drv; // Drives for the slot on the wire
  logic [4:0] cmd_s1, cmd_s2; // Pin synchronisers: cmd, dat
  logic [1:0] ctl_s1, ctl_s2; // Pin synchronisers: wp, cd
  logic [3:0] gpi_a1, gpi_a2; // Data pins in carrier domain
  logic [3:0] gpi_b1, gpi_b2; // Carrier samples into ref_clk

  // Clamp the divider so a too small request can neither beat the rate limit
  // nor sample the pins before the synchroniser has seen this slot's bits
  always_comb
  begin
    if (clk_half < `SDGP_DIV_W'(`SDGP_HALF_FLOOR))
      half_eff = `SDGP_DIV_W'(`SDGP_HALF_FLOOR);
    else
      half_eff = clk_half;
  end

  // Mode register; one select steers every shared pin
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      mode <= SDGP_GP;
    else
      mode <= sd_mode ? SDGP_SD : SDGP_GP;
  end

  // Pin synchronisers on the system clock; first stage read only by the second
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cmd_s1 <= 5'h1F;
      cmd_s2 <= 5'h1F;
      ctl_s1 <= 2'h3;
      ctl_s2 <= 2'h3;
    end
    else
    begin
      cmd_s1 <= {gen_out_one_in, card_data_in};
      cmd_s2 <= cmd_s1;
      ctl_s1 <= {gen_out_two_in, card_present_n};
      ctl_s2 <= ctl_s1;
    end
  end

  // General purpose inputs are sampled on the carrier clock, then carried
  // across as levels; slow static levels make per-bit sync acceptable
  always_ff @(posedge gp_in_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gpi_a1 <= 4'hF;
      gpi_a2 <= 4'hF;
    end
    else
    begin
      gpi_a1 <= card_data_in;
      gpi_a2 <= gpi_a1;
    end
  end

  // Carrier samples into the system domain
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gpi_b1 <= 4'hF;
      gpi_b2 <= 4'hF;
    end
    else
    begin
      gpi_b1 <= gpi_a2;
      gpi_b2 <= gpi_b1;
    end
  end

  // Status outputs
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gen_in_level <= 4'hF;
      card_present <= 1'b0;
      card_wp <= 1'b0;
    end
    else
    begin
      gen_in_level <= gpi_b2;
      // Inputs only meaningful in SD mode; held low otherwise
      card_present <= (mode == SDGP_SD) && !ctl_s2[0];
      card_wp <= (mode == SDGP_SD) && ctl_s2[1];
    end
  end

  // Shift engine: each SD clock period carries exactly one slot
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state <= SDGP_IDLE;
      div_cnt <= `SDGP_DIV_W'h0;
      cur_tx <= '1;
      cur_drv <= '0;
      slot_ready <= 1'b0;
      slot_rx <= '1;
      slot_rx_valid <= 1'b0;
    end
    else
    begin
      slot_ready <= 1'b0;
      slot_rx_valid <= 1'b0;
      case (state)
        SDGP_IDLE:
        begin
          // Take a slot only in SD mode; clock rests low between slots
          if (mode == SDGP_SD && slot_valid && !slot_ready)
          begin
            cur_tx <= slot_tx;
            cur_drv <= slot_drv;
            slot_ready <= 1'b1;
            div_cnt <= half_eff - `SDGP_DIV_W'h1;
            state <= SDGP_LOW;
          end
        end
        SDGP_LOW:
        begin
          if (div_cnt == `SDGP_DIV_W'h0)
          begin
            // Rising edge: card samples, host captures one bit per line
            slot_rx <= '{cmd: cmd_s2[4], dat: cmd_s2[3:0]};
            slot_rx_valid <= 1'b1;
            div_cnt <= half_eff - `SDGP_DIV_W'h1;
            state <= SDGP_HIGH;
          end
          else
            div_cnt <= div_cnt - `SDGP_DIV_W'h1;
        end
        SDGP_HIGH:
        begin
          if (div_cnt == `SDGP_DIV_W'h0)
            state <= SDGP_IDLE;
          else
            div_cnt <= div_cnt - `SDGP_DIV_W'h1;
        end
        default:
          state <= SDGP_IDLE;
      endcase
      if (mode != SDGP_SD)
      begin
        state <= SDGP_IDLE;
        cur_drv <= '0;
      end
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      gen_out_zero <= 1'b0;
      gen_out_one <= 1'b0;
      gen_out_one_oe <= 1'b1;
      gen_out_two <= 1'b0;
      gen_out_two_oe <= 1'b1;
      gen_out_three <= 1'b0;
      gen_out_three_oe <= 1'b1;
      card_data_out <= 4'h0;
      card_data_oe <= 4'h0;
    end
    else if (mode == SDGP_SD)
    begin
      gen_out_zero <= (state == SDGP_HIGH);
      // Init: drive only a low, let pull-up make the high
      if (cmd_init && cur_drv.cmd_od)
      begin
        gen_out_one <= 1'b0;
        gen_out_one_oe <= cur_drv.cmd_oe && !cur_tx.cmd;
      end
      else
      begin
        gen_out_one <= cur_tx.cmd;
        gen_out_one_oe <= cur_drv.cmd_oe;
      end
      gen_out_two <= 1'b0;
      gen_out_two_oe <= 1'b0;
      gen_out_three <= 1'b0;
      gen_out_three_oe <= 1'b0;
      card_data_out <= cur_tx.dat;
      card_data_oe <= cur_drv.dat_oe;
    end
    else
    begin
      {gen_out_three, gen_out_two, gen_out_one, gen_out_zero} <= gen_out_val;
      gen_out_one_oe <= 1'b1;
      gen_out_two_oe <= 1'b1;
      gen_out_three_oe <= 1'b1;
      card_data_out <= 4'h0;
      card_data_oe <= 4'h0;
    end
  end

endmodule // sdgp_pin_share

/* File: src/sdgp_defs.svh */
// Constants of the SD / general purpose pin-sharing block.
// Assumes a 100 MHz system clock; included by the top module and the bench.
`ifndef SDGP_DEFS_SVH
`define SDGP_DEFS_SVH
// System clock rate in MHz
`define SDGP_SYS_MHZ 100
// Highest SD clock the block may produce, in MHz
`define SDGP_SD_MAX_MHZ 48
// Least half period of SD clock in system cycles: ceil(SYS / (2 * MAX))
`define SDGP_HALF_MIN ((`SDGP_SYS_MHZ + 2 * `SDGP_SD_MAX_MHZ - 1) / (2 * `SDGP_SD_MAX_MHZ))
// Least half period that lets a pin sample pass the two-stage synchroniser
// and still land in its own slot
`define SDGP_HALF_SYNC 4
// Floor applied to the requested half period
`define SDGP_HALF_FLOOR ((`SDGP_HALF_MIN > `SDGP_HALF_SYNC) ? `SDGP_HALF_MIN : `SDGP_HALF_SYNC)
// Width of the divider counter
`define SDGP_DIV_W 8
// Reset value of the general purpose outputs
`define SDGP_GPO_RST 4'h0
// Number of shared data pins
`define SDGP_NDAT 4
// Mode encodings
`define SDGP_MODE_GP 1'h0
`define SDGP_MODE_SD 1'h1
`endif

/* File: src/sdgp_pkg.sv */
// Types of the SD / general purpose pin-sharing block.
// Constants live in sdgp_defs.svh.
package sdgp_pkg;
  // Pin function selection
  typedef enum logic [0:0] {SDGP_GP = 1'b0, SDGP_SD = 1'b1} sdgp_mode_e;
  // Shift engine states, one-hot
  typedef enum logic [2:0] {
    SDGP_IDLE = 3'b001,
    SDGP_LOW = 3'b010,
    SDGP_HIGH = 3'b100
  } sdgp_state_e;
  // One bit slot of the SD link: command plus four data lines
  typedef struct packed {
    logic cmd;
    logic [3:0] dat;
  } sdgp_bits_s;
  // Per-bit output enables and command open-drain select of the SD link
  typedef struct packed {
    logic cmd_oe;
    logic cmd_od;
    logic [3:0] dat_oe;
  } sdgp_drive_s;
endpackage

/* File: dv/sdgp_pin_share_checker.sv */
// Assertions on the ports of the pin-sharing block.
// Assumes the bench holds slot inputs steady until each slot ends.
`timescale 1ns/1ps
module sdgp_pin_share_checker
  import sdgp_pkg::*;
(
  // Clock, reset and controls
  input wire logic ref_clk, rstn, sd_mode, cmd_init, slot_ready, slot_rx_valid,
  input wire logic [3:0] gen_out_val,
  input wire sdgp_bits_s slot_tx,
  input wire sdgp_drive_s slot_drv,
  // Pins and status
  input wire logic card_present, card_wp, card_present_n, gen_out_two_in, gen_out_zero,
  input wire logic gen_out_one, gen_out_one_oe, gen_out_two, gen_out_two_oe,
  input wire logic gen_out_three, gen_out_three_oe,
  input wire logic [3:0] card_data_out, card_data_oe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Pins of a slot are settled three edges after it is taken
  sequence s_taken; slot_ready ##3 1; endsequence
  // Clock low, bit sampled, then clock high
  sequence s_bit; ##[1:3] !gen_out_zero ##[1:300] slot_rx_valid ##[1:3] gen_out_zero; endsequence
  property p_gp; (!sd_mode && $stable(gen_out_val))[*3] |-> gen_out_one_oe && gen_out_two_oe
    && gen_out_three_oe && card_data_oe == 4'h0
    && {gen_out_three, gen_out_two, gen_out_one, gen_out_zero} == gen_out_val; endproperty
  a_gp: assert property (p_gp) else $error("gp pins wrong");
  property p_sd; sd_mode[*3] |-> !gen_out_two_oe && !gen_out_three_oe; endproperty
  a_sd: assert property (p_sd) else $error("sd input pin driven");
  property p_cd; (sd_mode && $stable(card_present_n) && $stable(gen_out_two_in))[*5]
    |-> card_present == !card_present_n && card_wp == gen_out_two_in; endproperty
  a_cd: assert property (p_cd) else $error("card status wrong");
  property p_clk; $past(sd_mode, 3) && sd_mode && $rose(gen_out_zero) |=> gen_out_zero;
  endproperty
  a_clk: assert property (p_clk) else $error("sd clock high too short");
  property p_slot; slot_ready |-> s_bit; endproperty
  a_slot: assert property (p_slot) else $error("slot clock wrong");
  property p_data; s_taken |-> card_data_oe == slot_drv.dat_oe
    && ((card_data_out ^ slot_tx.dat) & slot_drv.dat_oe) == 4'h0; endproperty
  a_data: assert property (p_data) else $error("data pins wrong");
  property p_od; s_taken ##0 (cmd_init && slot_drv.cmd_od && slot_drv.cmd_oe)
    |-> gen_out_one_oe == !slot_tx.cmd && !(gen_out_one && gen_out_one_oe); endproperty
  a_od: assert property (p_od) else $error("cmd not open drain");
  property p_pp; s_taken ##0 (!cmd_init && slot_drv.cmd_oe)
    |-> gen_out_one_oe && gen_out_one == slot_tx.cmd; endproperty
  a_pp: assert property (p_pp) else $error("cmd not push-pull");
endmodule // sdgp_pin_share_checker

bind sdgp_pin_share sdgp_pin_share_checker u_chk (.ref_clk, .rstn, .sd_mode, .cmd_init,
  .slot_ready, .slot_rx_valid, .gen_out_val, .slot_tx, .slot_drv, .card_present, .card_wp,
  .card_present_n, .gen_out_two_in, .gen_out_zero, .gen_out_one, .gen_out_one_oe,
  .gen_out_two, .gen_out_two_oe, .gen_out_three, .gen_out_three_oe, .card_data_out,
  .card_data_oe);

/* File: dv/sdgp_card_model.sv */
// Card socket on the carrier board, with pull-ups on released lines.
// Assumes pin values and enables straight from the block.
`timescale 1ns/1ps
module sdgp_card_model
(
  // Pins from the block
  input wire logic clk_pin, cmd_pin, cmd_oe,
  input wire logic [3:0] dat_pin, dat_oe,
  // Card behaviour set by the bench
  input wire logic card_drive,
  input wire logic [3:0] card_dat,
  // Resolved levels seen by the block
  output logic cmd_wire,
  output logic [3:0] dat_wire
);
  logic drive_q = 1'b0; // Card drives data this clock
  logic [3:0] dat_q = 4'hF; // Card data held for one whole clock
  // New bit only on the clock fall, so each clock moves one bit
  always @(negedge clk_pin)
  begin
    drive_q <= card_drive;
    dat_q <= card_dat;
  end
  // Released command line reads high through its pull-up
  assign cmd_wire = cmd_oe ? cmd_pin : 1'b1;
  // Card drives both levels; released lines read high
  assign dat_wire = (dat_oe & dat_pin) | (~dat_oe & (drive_q ? dat_q : 4'hF));
endmodule // sdgp_card_model

/* File: dv/sdgp_pin_share_tb_top.sv */
// Bench of the pin-sharing block with a card socket model.
// Assumes the checker binds itself to the block.
`timescale 1ns/1ps
`include "sdgp_defs.svh"
module sdgp_pin_share_tb_top
  import sdgp_pkg::*;
;
  logic ref_clk = 0, gp_in_clk = 0, rstn = 0, sd_mode = 0, cmd_init = 0, slot_valid = 0;
  logic card_drive = 0, card_present_n = 1, wp_pin = 0;
  logic [3:0] gen_out_val = 4'h0, card_dat = 4'h0;
  logic [`SDGP_DIV_W-1:0] clk_half = 8'h06; // Long enough for the input synchronisers
  sdgp_bits_s slot_tx = '0, slot_rx;
  sdgp_drive_s slot_drv = '0;
  logic slot_ready, slot_rx_valid, card_present, card_wp, clk_pin, cmd_pin, cmd_oe, cmd_wire;
  logic [3:0] gen_in_level, dat_pin, dat_oe, dat_wire;
  int mismatches = 0, samples_checked = 0;
  always #5 ref_clk = ~ref_clk;
  always #6 gp_in_clk = ~gp_in_clk;
  sdgp_pin_share DUT (.ref_clk(ref_clk), .rstn(rstn), .gp_in_clk(gp_in_clk),
    .sd_mode(sd_mode), .cmd_init(cmd_init), .gen_out_val(gen_out_val), .clk_half(clk_half),
    .slot_valid(slot_valid), .slot_tx(slot_tx), .slot_drv(slot_drv), .slot_ready(slot_ready),
    .slot_rx(slot_rx), .slot_rx_valid(slot_rx_valid), .gen_in_level(gen_in_level),
    .card_present(card_present), .card_wp(card_wp), .gen_out_zero(clk_pin),
    .gen_out_one_in(cmd_wire), .gen_out_one(cmd_pin), .gen_out_one_oe(cmd_oe),
    .gen_out_two_in(wp_pin), .gen_out_two(), .gen_out_two_oe(), .card_present_n(card_present_n),
    .gen_out_three(), .gen_out_three_oe(), .card_data_in(dat_wire), .card_data_out(dat_pin),
    .card_data_oe(dat_oe));
  sdgp_card_model u_card (.clk_pin, .cmd_pin, .cmd_oe, .dat_pin, .dat_oe, .card_drive,
    .card_dat, .cmd_wire, .dat_wire);
  // Step to just after a rising edge
  task cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task chk(input logic [4:0] got, input logic [4:0] exp);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  end
  endtask
  // One slot: hold the request until taken, then compare what came back
  task t_slot(input sdgp_bits_s tx, input sdgp_drive_s drv, input logic init,
    input logic [4:0] exp);
    int i;
  begin
    slot_tx = tx;
    slot_drv = drv;
    cmd_init = init;
    slot_valid = 1;
    for (i = 0; i < 600 && slot_ready !== 1'b1; i++) cyc(1);
    cyc(1); // Request stands through the edge that samples ready high
    slot_valid = 0;
    for (i = 0; i < 600 && slot_rx_valid !== 1'b1; i++) cyc(1);
    chk(slot_rx, exp);
    cyc(16); // Inputs stay put while the pins are judged
  end
  endtask
  // Outputs follow their values; a clock fall loads the carrier's levels
  task t_gp;
  begin
    card_drive = 1;
    card_dat = 4'h5;
    gen_out_val = 4'hB;
    cyc(3);
    gen_out_val = 4'hA;
    cyc(10);
    chk({1'b0, gen_in_level}, 5'h05);
    chk({3'h0, cmd_pin, clk_pin}, 5'h02);
  end
  endtask
  task t_sd;
  begin
    sd_mode = 1;
    card_drive = 0;
    card_present_n = 0;
    wp_pin = 1;
    cyc(8);
    chk({3'h0, card_present, card_wp}, 5'h03);
    t_slot(5'h1A, 6'h2F, 0, 5'h1A);
    clk_half = 8'h01; // Below the floor, must be clamped
    // Card data is loaded by the clock fall that ends the next slot
    card_drive = 1;
    card_dat = 4'h3;
    t_slot(5'h05, 6'h2F, 0, 5'h05);
    clk_half = 8'h06;
    t_slot(5'h10, 6'h30, 1, 5'h13);
    t_slot(5'h00, 6'h30, 1, 5'h03);
    card_present_n = 1;
    wp_pin = 0;
    cyc(8);
    chk({3'h0, card_present, card_wp}, 5'h00);
  end
  endtask
  // Slots offered in general purpose mode are never taken
  task t_refuse;
  begin
    sd_mode = 0;
    card_present_n = 0; // A card on the pin must not show in this mode
    cyc(4);
    slot_valid = 1;
    repeat (10)
    begin
      cyc(1);
      chk({3'h0, card_present, slot_ready}, 5'h00);
    end
    slot_valid = 0;
  end
  endtask
  task end_sim;
  begin
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    cyc(3);
    rstn = 1;
    cyc(2);
    t_gp();
    t_sd();
    t_refuse();
    end_sim();
  end
  // Whole run takes about 140 cycles; far beyond that means a hang
  initial
  begin
    #20000;
    mismatches++;
    end_sim();
  end
endmodule // sdgp_pin_share_tb_top
